//--- rtl/dvs_defines.svh
// Constants of the setpoint ramp controller: offsets, fields, reset values, timing.
// Assumes it is included by bare name by the package and the design modules.
`ifndef DVS_DEFINES_SVH
`define DVS_DEFINES_SVH

// Register addresses carried by the address byte, bits D2..D0.
`define DVS_ADDR_PRESET0    3'h0
`define DVS_ADDR_PRESET3    3'h3
`define DVS_ADDR_CTRL       3'h4
`define DVS_ADDR_STAT       3'h5

// Field positions.
`define DVS_MODE_BIT        7
`define DVS_CTRL_SLEW_HI    2
`define DVS_CTRL_RAMPDN_BIT 3
`define DVS_STAT_WARN_BIT   0
`define DVS_STAT_SHUT_BIT   1
`define DVS_CODE_MASK6      7'h3F
`define DVS_CODE_MASK7      7'h7F
`define DVS_READ_NONE       8'h00

// Preset reset values, power save mode, per variant.
`define DVS_RST6_P0         8'h3F
`define DVS_RST6_P1         8'h17
`define DVS_RST6_P2         8'h3F
`define DVS_RST6_P3         8'h21
`define DVS_RST7_P0         8'h2E
`define DVS_RST7_P1         8'h5A
`define DVS_RST7_P2         8'h42
`define DVS_RST7_P3         8'h42

// Setpoint to millivolt mapping.
`define DVS_MV_BASE6        11'h302
`define DVS_MV_BASE7        11'h1F4
`define DVS_MV_STEP         11'h00A

// Step timing: base interval 0.3125 us at code 0, clock period 10 ns.
`define DVS_CLK_PERIOD_PS   10000
`define DVS_STEP_BASE_PS    312500
`define DVS_FRAC_SCALE      4
`define DVS_FRAC_ADD        8'h04
`define DVS_STEP_BASE_X4    ((`DVS_STEP_BASE_PS * `DVS_FRAC_SCALE) / `DVS_CLK_PERIOD_PS)

`endif

//--- rtl/dvs_pin_sync.sv
// Three-flop synchroniser for the asynchronous pin group.
// Assumes all pins are static levels; a change counts once flops two and three agree.
`timescale 1ns/10ps
`include "dvs_defines.svh"

module dvs_pin_sync (
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    // Pins
    input  wire dvs_pkg::dvs_pins_t pins_in,
    output dvs_pkg::dvs_pins_t   pins_out
);

    dvs_pkg::dvs_sync_t st_q;
    dvs_pkg::dvs_sync_t st_d;

    always_comb begin
        st_d        = st_q;
        st_d.f1     = pins_in;
        st_d.f2     = st_q.f1;
        st_d.f3     = st_q.f2;
        // Only flops two and three are compared; flop one feeds flop two alone.
        st_d.stable = (st_q.f2 & ~(st_q.f2 ^ st_q.f3)) | (st_q.stable & (st_q.f2 ^ st_q.f3));
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_out = st_q.stable;

endmodule

//--- rtl/dvs_pkg.sv
// Types shared by the setpoint ramp controller modules.
// Assumes dvs_defines.svh sits beside it.
`include "dvs_defines.svh"

package dvs_pkg;

    // Synchronised pin group, one bit per pin.
    typedef struct packed {
        logic logic_uv;
        logic analog_uv;
        logic temp_cool;
        logic temp_over;
        logic temp_warn;
        logic preset_select_hi;
        logic preset_select_lo;
        logic enable;
    } dvs_pins_t;

    typedef struct packed {
        dvs_pins_t f1;
        dvs_pins_t f2;
        dvs_pins_t f3;
        dvs_pins_t stable;
    } dvs_sync_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [8:0] pre;
        logic       step;
    } dvs_tmr_t;

    typedef struct packed {
        logic [3:0][7:0] preset;
        logic [2:0]      slew_code;
        logic            light_load_ramp_down;
        logic            thermal_shutdown_flag;
        logic            therm_off;
        logic [6:0]      setpoint_code;
        logic [10:0]     mv;
        logic            force_pwm;
        logic            stage_on;
        logic [7:0]      rdata;
    } dvs_ctl_t;

endpackage

//--- rtl/dvs_ramp_control.sv
// Setpoint ramp and preset control of a step-down converter.
// Assumes a serial slave outside delivers one register write pulse per completed
// write transaction and one read pulse per register read, and that the
// temperature and supply indications arrive as asynchronous comparator levels.
//
// Operation
// [R01] 6-bit variant: code 0 is 770 mV, 10 mV per code.
// [R02] 7-bit variant: code 0 is 500 mV, 10 mV per code.
// [R03] New setpoint of the active preset applies once its write completes.
// [R04] Bit 7 picks forced PWM per preset, effective even while active.
// [R05] Global 3-bit slew code: 32 mV/us divided by two to the code.
// [R06] One 10 mV step every 0.3125 us times two to the code.
// [R07] 6-bit steps 10 mV; 7-bit steps 20 mV at half rate, final 10 mV.
// [R08] Forced PWM: both rising and falling transitions follow the slope.
// [R09] Power save: rising transitions still follow the slope.
// [R10] Power save falls follow the slope only with light-load ramp-down set.
// [R11] Thermal warning bit follows the early warning indication.
// [R12] Over temperature turns the power stage off; registers and interface stay.
// [R13] Switching resumes only once the cool indication arrives.
// [R14] Thermal shutdown bit latches until the host clears it.
// [R15] Analog undervoltage stops the stage at once and resets registers.
// [R16] Logic undervoltage resets all registers.
// [R17] Register access works regardless of converter state.
// [R18] Step timing comes from the internal clock.
// [R19] Select pins pick preset 0 to 3, registers at 0x00 to 0x03.
// [R20] After enable the setpoint starts from minimum and climbs to target.
// [R21] Preset change ramps from present setpoint exactly onto the new target.
// [R22] Target change mid-ramp redirects from the present setpoint.
`timescale 1ns/10ps
`include "dvs_defines.svh"

module dvs_ramp_control #(
    parameter bit WIDE_CODE = 1'b0
) (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    // Pins from the host and the analog side
    input  wire logic        ENABLE_IN,
    input  wire logic        PRESET_SELECT_LO_IN,
    input  wire logic        PRESET_SELECT_HI_IN,
    input  wire logic        TEMP_WARN_IN,
    input  wire logic        TEMP_OVER_IN,
    input  wire logic        TEMP_COOL_IN,
    input  wire logic        ANALOG_SUPPLY_UV_IN,
    input  wire logic        LOGIC_SUPPLY_UV_IN,
    // Register port from the serial slave
    input  wire logic [2:0]  REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic [7:0]       REG_RDATA_OUT,
    // Converter control
    output logic [6:0]       SETPOINT_CODE_OUT,
    output logic [10:0]      SETPOINT_MV_OUT,
    output logic             FORCE_PWM_OUT,
    output logic             TRACK_FALL_OUT,
    output logic             POWER_STAGE_ON_OUT,
    output logic             THERMAL_WARNING_OUT,
    output logic             THERMAL_SHUTDOWN_OUT
);

    ////////////////////////////////////////////////////////////////////////////////

    dvs_pkg::dvs_pins_t pins_raw;
    dvs_pkg::dvs_pins_t pins;
    dvs_pkg::dvs_ctl_t  st_q;
    dvs_pkg::dvs_ctl_t  st_d;
    logic               step;
    logic               run;
    logic               reg_rst;
    logic [1:0]         sel;
    logic [6:0]         tgt;
    logic [6:0]         diff;
    logic [6:0]         code_mask;
    logic               active;
    logic               track_fall;

    assign pins_raw = '{logic_uv:         LOGIC_SUPPLY_UV_IN,
                        analog_uv:        ANALOG_SUPPLY_UV_IN,
                        temp_cool:        TEMP_COOL_IN,
                        temp_over:        TEMP_OVER_IN,
                        temp_warn:        TEMP_WARN_IN,
                        preset_select_hi: PRESET_SELECT_HI_IN,
                        preset_select_lo: PRESET_SELECT_LO_IN,
                        enable:           ENABLE_IN};

    dvs_pin_sync u_sync (
        .clk_in   (MCLK_IN),
        .rst_in   (RST_IN),
        .pins_in  (pins_raw),
        .pins_out (pins)
    );

    dvs_step_timer u_timer (
        .clk_in       (MCLK_IN),
        .rst_in       (reg_rst),
        .run_in       (run),
        .slew_code_in (st_q.slew_code),
        .half_rate_in (WIDE_CODE),
        .step_out     (step)
    );

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [10:0] code_to_mv(input logic [6:0] code);
        logic [10:0] base;
        base = WIDE_CODE ? `DVS_MV_BASE7 : `DVS_MV_BASE6;
        return base + 11'({4'h0, code} * `DVS_MV_STEP);
    endfunction

    function automatic dvs_pkg::dvs_ctl_t reset_state();
        dvs_pkg::dvs_ctl_t r;
        r           = '0;
        r.preset[0] = WIDE_CODE ? `DVS_RST7_P0 : `DVS_RST6_P0;
        r.preset[1] = WIDE_CODE ? `DVS_RST7_P1 : `DVS_RST6_P1;
        r.preset[2] = WIDE_CODE ? `DVS_RST7_P2 : `DVS_RST6_P2;
        r.preset[3] = WIDE_CODE ? `DVS_RST7_P3 : `DVS_RST6_P3;
        r.mv        = code_to_mv(7'h00);
        return r;
    endfunction

    // Undervoltage acts as a register reset; it reaches the logic after the
    // synchroniser, so the power stage is also gated from the raw analog pin below.
    assign reg_rst   = RST_IN | pins.analog_uv | pins.logic_uv; // R15 R16
    assign code_mask = WIDE_CODE ? `DVS_CODE_MASK7 : `DVS_CODE_MASK6;
    assign sel       = {pins.preset_select_hi, pins.preset_select_lo}; // R19
    assign tgt       = st_q.preset[sel][6:0] & code_mask; // R21
    assign active    = pins.enable & ~st_q.therm_off;
    assign run       = active & (st_q.setpoint_code != tgt);
    assign track_fall = st_q.preset[sel][`DVS_MODE_BIT] | st_q.light_load_ramp_down; // R08 R10

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_d  = st_q;
        diff  = 7'h00;
        // Register writes are taken whatever the converter is doing.
        if (REG_WR_IN) begin // R17
            case (REG_ADDR_IN)
                3'h0, 3'h1, 3'h2, 3'h3: begin
                    st_d.preset[REG_ADDR_IN[1:0]] = {REG_WDATA_IN[`DVS_MODE_BIT],
                                                     REG_WDATA_IN[6:0] & code_mask}; // R03
                end
                `DVS_ADDR_CTRL: begin
                    st_d.slew_code            = REG_WDATA_IN[`DVS_CTRL_SLEW_HI:0]; // R05
                    st_d.light_load_ramp_down = REG_WDATA_IN[`DVS_CTRL_RAMPDN_BIT];
                end
                `DVS_ADDR_STAT: begin
                    if (REG_WDATA_IN[`DVS_STAT_SHUT_BIT]) begin
                        st_d.thermal_shutdown_flag = 1'b0; // R14
                    end
                end
                default: begin
                end
            endcase
        end
        // Thermal shutdown with hysteresis; the set is placed after the clear so
        // an over temperature in the clearing cycle is not lost.
        if (pins.temp_over) begin
            st_d.therm_off             = 1'b1; // R12
            st_d.thermal_shutdown_flag = 1'b1; // R14
        end else if (pins.temp_cool) begin
            st_d.therm_off = 1'b0; // R13
        end
        // Setpoint ramp.
        if (!active) begin
            st_d.setpoint_code = 7'h00; // R20
        end else if (st_q.setpoint_code < tgt) begin
            diff = tgt - st_q.setpoint_code;
            if (step) begin
                st_d.setpoint_code = st_q.setpoint_code + // R09
                    ((WIDE_CODE && diff >= 7'h02) ? 7'h02 : 7'h01); // R07
            end
        end else if (st_q.setpoint_code > tgt) begin
            diff = st_q.setpoint_code - tgt;
            if (!track_fall) begin
                // Power save without tracking: the stage is not made to follow.
                st_d.setpoint_code = tgt; // R10
            end else if (step) begin
                st_d.setpoint_code = st_q.setpoint_code - // R22
                    ((WIDE_CODE && diff >= 7'h02) ? 7'h02 : 7'h01); // R07
            end
        end
        st_d.mv        = code_to_mv(st_d.setpoint_code); // R01 R02
        st_d.force_pwm = st_d.preset[sel][`DVS_MODE_BIT]; // R04
        st_d.stage_on  = pins.enable & ~st_d.therm_off;
        // Read answers; unmapped addresses return zero.
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                3'h0, 3'h1, 3'h2, 3'h3: begin
                    st_d.rdata = st_q.preset[REG_ADDR_IN[1:0]];
                end
                `DVS_ADDR_CTRL: begin
                    st_d.rdata = {4'h0, st_q.light_load_ramp_down, st_q.slew_code};
                end
                `DVS_ADDR_STAT: begin
                    st_d.rdata = {6'h00, st_q.thermal_shutdown_flag, pins.temp_warn}; // R11
                end
                default: begin
                    st_d.rdata = `DVS_READ_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (reg_rst) begin
            st_q <= reset_state(); // R15 R16
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign REG_RDATA_OUT        = st_q.rdata;
    assign SETPOINT_CODE_OUT    = st_q.setpoint_code;
    assign SETPOINT_MV_OUT      = st_q.mv;
    assign FORCE_PWM_OUT        = st_q.force_pwm;
    assign TRACK_FALL_OUT       = track_fall;
    // The raw pin stops the stage without waiting for the synchroniser.
    assign POWER_STAGE_ON_OUT   = st_q.stage_on & ~ANALOG_SUPPLY_UV_IN; // R15
    assign THERMAL_WARNING_OUT  = pins.temp_warn; // R11
    assign THERMAL_SHUTDOWN_OUT = st_q.thermal_shutdown_flag;

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (reg_rst);

    sequence s_code_rises;
        active && (st_q.setpoint_code < tgt) && step;
    endsequence

    sequence s_code_one_up;
        (SETPOINT_CODE_OUT > $past(SETPOINT_CODE_OUT)) &&
        (SETPOINT_CODE_OUT <= $past(tgt));
    endsequence

    chk_mv_map_narrow: assert property ( // R01
        !WIDE_CODE |-> SETPOINT_MV_OUT == 11'h302 + 11'({4'h0, SETPOINT_CODE_OUT} * 11'h00A))
        else $error("setpoint millivolts wrong for narrow code");

    chk_mv_map_wide: assert property ( // R02
        WIDE_CODE |-> SETPOINT_MV_OUT == 11'h1F4 + 11'({4'h0, SETPOINT_CODE_OUT} * 11'h00A))
        else $error("setpoint millivolts wrong for wide code");

    chk_write_active_preset: assert property ( // R03
        (REG_WR_IN && REG_ADDR_IN[2] == 1'b0 && REG_ADDR_IN[1:0] == sel) ##1 (sel == $past(sel))
        |-> tgt == ($past(REG_WDATA_IN[6:0]) & code_mask))
        else $error("active preset write not reflected in target");

    chk_mode_follows_preset: assert property ( // R04
        (REG_WR_IN && REG_ADDR_IN[2] == 1'b0 && REG_ADDR_IN[1:0] == sel) ##1 (sel == $past(sel))
        |-> FORCE_PWM_OUT == $past(REG_WDATA_IN[7]))
        else $error("mode bit of active preset not applied");

    chk_step_spacing: assert property ( // R06
        step |=> !step [*8])
        else $error("ramp steps closer than the base interval");

    chk_rise_step: assert property ( // R07
        s_code_rises |=> s_code_one_up and
        (SETPOINT_CODE_OUT - $past(SETPOINT_CODE_OUT) <= (WIDE_CODE ? 7'h02 : 7'h01)))
        else $error("rising step size wrong");

    chk_code_moves_on_step: assert property ( // R22
        active && !step && track_fall && $stable(active) ##1 active
        |-> $stable(SETPOINT_CODE_OUT))
        else $error("setpoint moved without a step while tracking");

    chk_shut_stage_off: assert property ( // R12
        st_q.therm_off |-> !POWER_STAGE_ON_OUT)
        else $error("power stage on during thermal shutdown");

    chk_shut_flag_sticky: assert property ( // R14
        $fell(THERMAL_SHUTDOWN_OUT) |->
        $past(REG_WR_IN && REG_ADDR_IN == 3'h5 && REG_WDATA_IN[1] && !pins.temp_over))
        else $error("shutdown flag cleared without host clear");

    chk_resume_needs_cool: assert property ( // R13
        $fell(st_q.therm_off) |-> $past(pins.temp_cool && !pins.temp_over))
        else $error("shutdown left without cool indication");

    chk_soft_start: assert property ( // R20
        !active |=> SETPOINT_CODE_OUT == 7'h00)
        else $error("setpoint not at minimum while inactive");

endmodule

//--- rtl/dvs_step_timer.sv
// Ramp step interval generator.
// Assumes a 100 MHz clock; the 0.3125 us base is not whole cycles, so a quarter-cycle
// accumulator keeps the average exact at the cost of one cycle of jitter.
`timescale 1ns/10ps
`include "dvs_defines.svh"

module dvs_step_timer (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       run_in,
    input  wire logic [2:0] slew_code_in,
    input  wire logic       half_rate_in,
    // Step pulse
    output logic            step_out
);

    dvs_pkg::dvs_tmr_t st_q;
    dvs_pkg::dvs_tmr_t st_d;
    logic [8:0]        acc_sum;

    function automatic logic [8:0] pre_limit(input logic [2:0] code, input logic half);
        logic [3:0] sh;
        sh = {1'b0, code} + {3'h0, half};
        return (9'h001 << sh) - 9'h001;
    endfunction

    always_comb begin
        st_d      = st_q;
        st_d.step = 1'b0;
        acc_sum   = {1'b0, st_q.acc} + {1'b0, `DVS_FRAC_ADD};
        if (!run_in) begin
            st_d.acc = 8'h00;
            st_d.pre = 9'h000;
        end else if (acc_sum >= 9'(`DVS_STEP_BASE_X4)) begin
            st_d.acc = 8'(acc_sum - 9'(`DVS_STEP_BASE_X4)); // R18
            if (st_q.pre >= pre_limit(slew_code_in, half_rate_in)) begin
                st_d.pre  = 9'h000;
                st_d.step = 1'b1; // R06
            end else begin
                st_d.pre = st_q.pre + 9'h001; // R05
            end
        end else begin
            st_d.acc = acc_sum[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign step_out = st_q.step;

endmodule

//--- verification/dvs_host_model.sv
// Host model: drives the register port and the preset select pins.
// Assumes the design samples requests on the rising clock edge.
`timescale 1ns/10ps

module dvs_host_model (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic [2:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in,
    // Preset select pins
    output logic            sel_lo_out,
    output logic            sel_hi_out
);
    initial begin
        addr_out = 3'h0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        sel_lo_out = 1'b0;
        sel_hi_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One pulse per completed write; idle lines show a new pattern so stale data
    // can never pass for a request.
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask

    task automatic select(input logic [1:0] idx);
        @(posedge clk_in);
        sel_hi_out <= idx[1];
        sel_lo_out <= idx[0];
    endtask
endmodule

//--- verification/dvs_ramp_control_bench.sv
// Self-checking bench of the setpoint ramp controller, 6-bit variant.
// Assumes the host model owns the register port and the preset select pins.
`timescale 1ns/10ps
`define DVS_EXPECT(what, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
end

module dvs_ramp_control_bench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b0;
    logic        t_warn = 1'b0, t_over = 1'b0, t_cool = 1'b0;
    logic        a_uv = 1'b0, l_uv = 1'b0;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic        wr, rd, sel_lo, sel_hi;
    logic [6:0]  code;
    logic [10:0] mv;
    logic        pwm, trk, stage, warn, shut;
    int          err_total = 0;
    int          comparisons = 0;

    always #5 mclk = ~mclk;

    dvs_host_model host (.clk_in(mclk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata), .sel_lo_out(sel_lo), .sel_hi_out(sel_hi));

    dvs_ramp_control #(.WIDE_CODE(1'b0)) DUT (
        .MCLK_IN(mclk), .RST_IN(rst), .ENABLE_IN(en),
        .PRESET_SELECT_LO_IN(sel_lo), .PRESET_SELECT_HI_IN(sel_hi),
        .TEMP_WARN_IN(t_warn), .TEMP_OVER_IN(t_over), .TEMP_COOL_IN(t_cool),
        .ANALOG_SUPPLY_UV_IN(a_uv), .LOGIC_SUPPLY_UV_IN(l_uv),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .SETPOINT_CODE_OUT(code), .SETPOINT_MV_OUT(mv),
        .FORCE_PWM_OUT(pwm), .TRACK_FALL_OUT(trk), .POWER_STAGE_ON_OUT(stage),
        .THERMAL_WARNING_OUT(warn), .THERMAL_SHUTDOWN_OUT(shut));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        `DVS_EXPECT("register read", e, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Follows a ramp; the first step after a start is not timed, since the
    // timer restarts when a ramp begins.
    task automatic wait_target(input logic [6:0] tgt, input bit stepped, input int slew);
        logic [6:0] prev;
        int         n;
        int         bad = 0, chg = 0, last = 0, ilo = 99999, ihi = 0;
        int         lo;
        lo = ((125 << slew) / 4) - 1;
        prev = code;
        for (n = 0; n < 20000 && code !== tgt; n++) begin
            @(posedge mclk);
            #1;
            if (code !== prev) begin
                if (stepped && code !== prev + 7'h01 && code !== prev - 7'h01) begin
                    bad++;
                end
                if (chg > 0 && n - last < ilo) begin
                    ilo = n - last;
                end
                if (chg > 0 && n - last > ihi) begin
                    ihi = n - last;
                end
                chg++;
                last = n;
                prev = code;
            end
        end
        `DVS_EXPECT("setpoint code", tgt, code);
        `DVS_EXPECT("single steps", 0, bad);
        if (stepped && chg > 2) begin
            `DVS_EXPECT("step interval", 1'b1, ilo >= lo && ihi <= lo + 3);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_defaults();
        rd_chk(3'h0, 8'h3F);
        rd_chk(3'h1, 8'h17);
        rd_chk(3'h2, 8'h3F);
        rd_chk(3'h3, 8'h21);
        host.write_reg(3'h4, 8'hFF);
        rd_chk(3'h4, 8'h0F);
        host.write_reg(3'h4, 8'h00);
        rd_chk(3'h5, 8'h00);
        host.write_reg(3'h7, 8'h5A);
        rd_chk(3'h7, 8'h00);
        $display("test_defaults done");
    endtask

    task automatic test_soft_start();
        host.select(2'h1);
        en <= 1'b1;
        wait_target(7'h17, 1'b1, 0);
        `DVS_EXPECT("millivolts", 11'd770 + 11'd10 * 11'h17, mv);
        `DVS_EXPECT("power stage", 1'b1, stage);
        `DVS_EXPECT("forced pwm", 1'b0, pwm);
        $display("test_soft_start done");
    endtask

    task automatic test_preset_switch();
        host.write_reg(3'h4, 8'h01);
        host.select(2'h3);
        wait_target(7'h21, 1'b1, 1);
        `DVS_EXPECT("millivolts", 11'd770 + 11'd10 * 11'h21, mv);
        $display("test_preset_switch done");
    endtask

    task automatic test_pwm_fall();
        host.write_reg(3'h3, 8'h90);
        settle(2);
        `DVS_EXPECT("forced pwm", 1'b1, pwm);
        `DVS_EXPECT("fall tracking", 1'b1, trk);
        wait_target(7'h10, 1'b1, 1);
        host.write_reg(3'h3, 8'hA0);
        wait_target(7'h20, 1'b1, 1);
        host.write_reg(3'h3, 8'h88);
        settle(200);
        `DVS_EXPECT("mid ramp", 1'b1, code > 7'h08 && code < 7'h20);
        host.write_reg(3'h3, 8'h98);
        wait_target(7'h18, 1'b1, 1);
        host.write_reg(3'h3, 8'h88);
        wait_target(7'h08, 1'b1, 1);
        $display("test_pwm_fall done");
    endtask

    task automatic test_psave_fall();
        host.write_reg(3'h3, 8'h05);
        settle(4);
        `DVS_EXPECT("fall tracking", 1'b0, trk);
        `DVS_EXPECT("untracked fall", 7'h05, code);
        host.write_reg(3'h4, 8'h08);
        host.write_reg(3'h3, 8'h0C);
        wait_target(7'h0C, 1'b1, 0);
        host.write_reg(3'h3, 8'h02);
        settle(2);
        `DVS_EXPECT("fall tracking", 1'b1, trk);
        wait_target(7'h02, 1'b1, 0);
        $display("test_psave_fall done");
    endtask

    task automatic test_thermal();
        t_warn <= 1'b1;
        settle(5);
        `DVS_EXPECT("warning", 1'b1, warn);
        rd_chk(3'h5, 8'h01);
        t_over <= 1'b1;
        settle(6);
        `DVS_EXPECT("power stage", 1'b0, stage);
        `DVS_EXPECT("shutdown flag", 1'b1, shut);
        rd_chk(3'h3, 8'h02);
        t_over <= 1'b0;
        settle(10);
        `DVS_EXPECT("power stage", 1'b0, stage);
        t_cool <= 1'b1;
        wait_target(7'h02, 1'b1, 0);
        `DVS_EXPECT("power stage", 1'b1, stage);
        t_cool <= 1'b0;
        t_warn <= 1'b0;
        settle(6);
        rd_chk(3'h5, 8'h02);
        host.write_reg(3'h5, 8'h02);
        rd_chk(3'h5, 8'h00);
        $display("test_thermal done");
    endtask

    task automatic test_undervoltage();
        host.write_reg(3'h0, 8'h05);
        @(posedge mclk);
        a_uv <= 1'b1;
        #1;
        `DVS_EXPECT("power stage", 1'b0, stage);
        settle(6);
        a_uv <= 1'b0;
        settle(8);
        rd_chk(3'h0, 8'h3F);
        rd_chk(3'h4, 8'h00);
        host.write_reg(3'h1, 8'h05);
        @(posedge mclk);
        l_uv <= 1'b1;
        settle(6);
        l_uv <= 1'b0;
        settle(8);
        rd_chk(3'h1, 8'h17);
        $display("test_undervoltage done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole run needs about 6000 cycles; 40000 leaves ample margin.
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        settle(5);
        test_defaults();
        test_soft_start();
        test_preset_switch();
        test_pwm_fall();
        test_psave_fall();
        test_thermal();
        test_undervoltage();
        end_of_test();
    end
endmodule
